/* File: rmd_pkg.sv */
// constants, register map and state types for the radio modem datapath
// assumes a 100 MHz pclk and an apb master on the register side
//
// Overview of operation
// - retime user async characters into synchronous stream
// - line rates 4800, 9600, 19200 set bit timing
// - seven-bit scrambler on transmit, descrambler on receive
// - nrzi encode transmit bits, decode receive bits
// - recovered stream becomes async characters to user
// - transmit-active steers shared filter to transmit path
// - filter cutoff follows selected rate, updates on change
// - reload synthesizer serially on every direction change
// - route data to radio, serial port, or both
// - three channel inputs choose the active channel
// - test switch sends tone at quarter rate
// - half-channel units never offer 19200 rate
// - entering adjustment on half-channel units forces 9600 rate
// - half-channel at 4800 selects reduced deviation
package rmd_pkg;
  ////////////////////////////////////////////////////////////////////////
  // clock and line rates
  localparam int CLK_HZ     = 100_000_000;
  localparam int RATE_4800  = 4800;
  localparam int RATE_9600  = 9600;
  localparam int RATE_19200 = 19200;
  localparam logic [1:0] RC_4800  = 2'h0;  // rate code values
  localparam logic [1:0] RC_9600  = 2'h1;
  localparam logic [1:0] RC_19200 = 2'h2;
  localparam int BIT_CNT_W  = 15;          // holds the slowest bit period
  ////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_POLY   = 8'h04;
  localparam logic [7:0] ADDR_SYN_RX = 8'h08;
  localparam logic [7:0] ADDR_SYN_TX = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // control field positions
  localparam int CTRL_RATE_LSB = 0;        // 2 bits
  localparam int CTRL_TXACT    = 2;
  localparam int CTRL_ROUTE_LSB = 3;       // bit3 radio, bit4 serial
  localparam int CTRL_ADJUST   = 5;
  // reset values
  localparam logic [1:0] RST_RATE  = RC_9600;
  localparam logic [1:0] RST_ROUTE = 2'h3;
  localparam logic [6:0] RST_POLY  = 7'h48;  // taps at stages 7 and 4
  ////////////////////////////////////////////////////////////////////////
  // synthesizer serial loader
  localparam int SYN_W       = 24;
  localparam int SYN_HALF_NS = 40;         // half period of loader clock
  localparam int SYN_HALF_CYC = (SYN_HALF_NS * (CLK_HZ / 1_000_000)
                                 + 999) / 1000;
  typedef enum logic [1:0] {
    SYN_IDLE  = 2'b00,
    SYN_SHIFT = 2'b01,
    SYN_LATCH = 2'b11
  } rmd_syn_st_t;
endpackage

/* File: rmd_synth_if.sv */
// hand-off between the control logic and the synthesizer loader
// assumes both ends on pclk
`timescale 1ns/1ps
`default_nettype none
interface rmd_synth_if;
  logic        start;  // one-cycle load request
  logic [23:0] word;   // frequency word, msb first
  logic        busy;   // loader active
  modport ctl (output start, output word, input busy);
  modport ldr (input start, input word, output busy);
endinterface
`default_nettype wire

/* File: rmd_codec.sv */
// scrambler plus nrzi line coder, or the matching decoder
// assumes tick is a one-cycle pulse per line bit
`timescale 1ns/1ps
`default_nettype none
module rmd_codec #(
  parameter bit DECODE = 1'b0          // 0 encode, 1 decode
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic       din,
  input  wire logic [6:0] poly,
  output logic            dout
);
  logic [6:0] sr_q;                     // scrambler history
  logic       lvl_q;                    // nrzi line level / last line bit
  logic       nrz_in;                   // decoded nrzi bit
  logic       scr;                      // scrambled or descrambled bit
  assign nrz_in = din ^ lvl_q;
  assign scr    = (DECODE ? nrz_in : din) ^ (^(poly & sr_q));
  ////////////////////////////////////////////////////////////////////////
  // history advances with the scrambled bit, so the descrambler self-syncs
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sr_q  <= 7'h00;
      lvl_q <= 1'b0;
      dout  <= 1'b0;
    end
    else if (tick)
    begin
      sr_q  <= {sr_q[5:0], DECODE ? nrz_in : scr};
      lvl_q <= DECODE ? din : (lvl_q ^ scr);
      dout  <= DECODE ? scr : (lvl_q ^ scr);
    end
endmodule
`default_nettype wire

/* File: rmd_synth_loader.sv */
// serial loader for the radio synthesizer: clock, data, latch enable
// assumes the interface start pulse only while busy is low
`timescale 1ns/1ps
`default_nettype none
module rmd_synth_loader
  import rmd_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  rmd_synth_if.ldr  sif,
  output logic      syn_clk,
  output logic      syn_data,
  output logic      syn_le
);
  rmd_syn_st_t st_q;                    // loader state
  logic [23:0] sh_q;                    // word being shifted
  logic [4:0]  idx_q;                   // bits left minus one
  logic [3:0]  div_q;                   // half period counter
  logic        half;                    // half period elapsed
  assign half     = (div_q == 4'(SYN_HALF_CYC - 1));
  assign sif.busy = (st_q != SYN_IDLE);
  ////////////////////////////////////////////////////////////////////////
  // data changes on falling clock, synth samples on rising
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_q <= SYN_IDLE; sh_q <= '0; idx_q <= '0; div_q <= '0;
      syn_clk <= 1'b0; syn_data <= 1'b0; syn_le <= 1'b0;
    end
    else
    begin
      div_q <= (st_q == SYN_IDLE || half) ? 4'h0 : div_q + 4'h1;
      case (st_q)
        SYN_IDLE:
          if (sif.start)
          begin
            sh_q <= sif.word; idx_q <= 5'(SYN_W - 1);
            syn_data <= sif.word[SYN_W-1]; st_q <= SYN_SHIFT;
          end
        SYN_SHIFT:
          if (half)
          begin
            syn_clk <= ~syn_clk;
            if (syn_clk && idx_q == 5'h00)
            begin
              st_q <= SYN_LATCH; syn_le <= 1'b1;
            end
            else if (syn_clk)
            begin
              idx_q <= idx_q - 5'h01; sh_q <= {sh_q[22:0], 1'b0};
              syn_data <= sh_q[22];
            end
          end
        SYN_LATCH:
          if (half)
          begin
            syn_le <= 1'b0; st_q <= SYN_IDLE;
          end
        default: st_q <= SYN_IDLE;
      endcase
    end
endmodule
`default_nettype wire

/* File: rmd_modem_top.sv */
// radio modem datapath top: apb registers, async/sync conversion,
// line coding, filter and path control, synthesizer reload
// assumes all pin inputs synchronous to pclk; line bits sampled on the
// local bit tick (clock recovery lives in the analog slicer stage)
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rmd_modem_top
  import rmd_pkg::*;
#(
  parameter int BIT_CYC_4800  = CLK_HZ / RATE_4800,   // bit periods
  parameter int BIT_CYC_9600  = CLK_HZ / RATE_9600,
  parameter int BIT_CYC_19200 = CLK_HZ / RATE_19200
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        user_txd,
  output logic             user_rxd,
  input  wire logic        radio_baseband_in,
  output logic             radio_baseband_out,
  output logic             filter_to_tx,
  output logic      [1:0]  filter_cutoff,
  output logic             dev_reduced,
  output logic      [2:0]  radio_channel,
  input  wire logic [2:0]  chan_sel,
  input  wire logic        test_sw,
  input  wire logic        half_channel,
  output logic             syn_clk,
  output logic             syn_data,
  output logic             syn_le
);
  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0]  rate_q;                  // selected rate code
  logic        tx_act_q;                // transmit active
  logic        tx_act_prev_q;           // for direction change detect
  logic [1:0]  route_q;                 // bit0 radio, bit1 serial port
  logic        adjust_q;                // adjustment procedure active
  logic [6:0]  poly_q;                  // scrambler taps
  logic [23:0] syn_rx_q;                // receive frequency word
  logic [23:0] syn_tx_q;                // transmit frequency word
  logic        syn_pend_q;              // reload waiting for loader
  logic        test_q;                  // test switch sampled
  logic [BIT_CNT_W-1:0] bit_cnt_q;      // bit period counter
  logic        tick;                    // one pulse per line bit
  logic        tick_d_q;                // tick delayed for decoder output
  logic [1:0]  tone_q;                  // quarter-rate tone divider
  // user -> modem character capture
  logic        ur_busy_q;               // character in progress
  logic [BIT_CNT_W-1:0] ur_cnt_q;       // sample point counter
  logic [3:0]  ur_idx_q;                // bit index in character
  logic [7:0]  ur_sh_q;                 // data bits
  logic [7:0]  hold_q;                  // captured character
  logic        hold_v_q;                // captured character waiting
  // synchronous transmit serializer
  logic [9:0]  tx_sh_q;                 // framed character
  logic [3:0]  tx_n_q;                  // bits left
  logic        tx_bit;                  // current synchronous bit
  logic        enc_out;                 // coded line bit
  // receive side
  logic        rx_in;                   // gated radio input
  logic        dec_out;                 // descrambled bit
  logic [3:0]  rf_n_q;                  // deframer bits left
  logic [7:0]  rf_sh_q;                 // deframer data
  logic [7:0]  rxc_q;                   // received character
  logic        rxc_v_q;                 // received character waiting
  logic [9:0]  ut_sh_q;                 // user port frame
  logic [3:0]  ut_n_q;                  // user port bits left
  logic        ut_bit;                  // user port bit
  // apb decode
  logic        setup;                   // setup phase
  logic        wr_en;                   // write takes effect
  logic        hit_ctrl;
  logic        hit_poly;
  logic        hit_srx;
  logic        hit_stx;
  logic        hit_stat;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [1:0]  wr_rate;
  logic        rate_ok;                 // write of a legal rate
  logic        adj_enter;               // adjust bit rising by write
  logic [BIT_CNT_W-1:0] bit_per;        // current bit period
  rmd_synth_if sif ();
  //////////////////////////////////////////////////////////////////////////
  // apb address decode and read mux
  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & pready;
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_poly = (paddr == ADDR_POLY);
  assign hit_srx  = (paddr == ADDR_SYN_RX);
  assign hit_stx  = (paddr == ADDR_SYN_TX);
  assign hit_stat = (paddr == ADDR_STATUS);
  assign mapped   = hit_ctrl | hit_poly | hit_srx | hit_stx | hit_stat;
  assign rd_mux   = hit_ctrl ? {26'h0, adjust_q, route_q, tx_act_q,
                                rate_q} :
                    hit_poly ? {25'h0, poly_q} :
                    hit_srx  ? {8'h0, syn_rx_q} :
                    hit_stx  ? {8'h0, syn_tx_q} :
                    hit_stat ? {23'h0, half_channel, dev_reduced, test_q,
                                radio_channel, sif.busy, rate_q} :
                               32'h0;
  //////////////////////////////////////////////////////////////////////////
  // apb answer: one access cycle, read data latched at setup
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;       // unmapped address errors
      prdata  <= (setup & ~pwrite) ? rd_mux : prdata;
    end
  //////////////////////////////////////////////////////////////////////////
  // rate legality and adjustment forcing
  assign wr_rate   = pwdata[CTRL_RATE_LSB +: 2];
  assign rate_ok   = (wr_rate == RC_4800) | (wr_rate == RC_9600) |
                     ((wr_rate == RC_19200) & ~half_channel);
  assign adj_enter = wr_en & hit_ctrl & pwdata[CTRL_ADJUST] & ~adjust_q;
  //////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rate_q   <= RST_RATE;
      tx_act_q <= 1'b0;
      route_q  <= RST_ROUTE;
      adjust_q <= 1'b0;
    end
    else if (wr_en & hit_ctrl)
    begin
      tx_act_q <= pwdata[CTRL_TXACT];
      route_q  <= pwdata[CTRL_ROUTE_LSB +: 2];
      adjust_q <= pwdata[CTRL_ADJUST];
      if (adj_enter & half_channel)
        rate_q <= RC_9600;
      else if (rate_ok)
        rate_q <= wr_rate;
    end
    else if (half_channel & (rate_q == RC_19200))
      rate_q <= RC_9600;
  //////////////////////////////////////////////////////////////////////////
  // polynomial and frequency word registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      poly_q   <= RST_POLY;
      syn_rx_q <= 24'h0;
      syn_tx_q <= 24'h0;
    end
    else
    begin
      if (wr_en & hit_poly)
        poly_q <= pwdata[6:0];
      if (wr_en & hit_srx)
        syn_rx_q <= pwdata[23:0];
      if (wr_en & hit_stx)
        syn_tx_q <= pwdata[23:0];
    end
  //////////////////////////////////////////////////////////////////////////
  // synthesizer reload on every direction change
  assign sif.start = syn_pend_q & ~sif.busy;
  assign sif.word  = tx_act_q ? syn_tx_q : syn_rx_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_act_prev_q <= 1'b0;
      syn_pend_q    <= 1'b0;
    end
    else
    begin
      tx_act_prev_q <= tx_act_q;
      if (tx_act_q != tx_act_prev_q)
        syn_pend_q <= 1'b1;
      else if (sif.start)
        syn_pend_q <= 1'b0;
    end
  rmd_synth_loader u_loader (
    .pclk     (pclk),
    .presetn  (presetn),
    .sif      (sif),
    .syn_clk  (syn_clk),
    .syn_data (syn_data),
    .syn_le   (syn_le)
  );
  //////////////////////////////////////////////////////////////////////////
  // filter, deviation and channel outputs
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      filter_to_tx  <= 1'b0;
      filter_cutoff <= RST_RATE;
      dev_reduced   <= 1'b0;
      radio_channel <= 3'h0;
      test_q        <= 1'b0;
    end
    else
    begin
      filter_to_tx  <= tx_act_q;
      filter_cutoff <= rate_q;
      dev_reduced   <= half_channel & (rate_q == RC_4800);
      radio_channel <= chan_sel;
      test_q        <= test_sw;
    end
  //////////////////////////////////////////////////////////////////////////
  // bit timing from the selected rate
  assign bit_per = (rate_q == RC_4800)  ? BIT_CNT_W'(BIT_CYC_4800) :
                   (rate_q == RC_19200) ? BIT_CNT_W'(BIT_CYC_19200) :
                                          BIT_CNT_W'(BIT_CYC_9600);
  assign tick    = (bit_cnt_q >= bit_per - 1'b1);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bit_cnt_q <= '0;
      tick_d_q  <= 1'b0;
      tone_q    <= 2'h0;
    end
    else
    begin
      bit_cnt_q <= tick ? '0 : bit_cnt_q + 1'b1;
      tick_d_q  <= tick;
      if (tick)
        tone_q <= tone_q + 2'h1;        // four bits per tone cycle
    end
  //////////////////////////////////////////////////////////////////////////
  // user port character capture, mid-bit sampling
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ur_busy_q <= 1'b0;
      ur_cnt_q  <= '0;
      ur_idx_q  <= 4'h0;
      ur_sh_q   <= 8'h00;
      hold_q    <= 8'h00;
    end
    else if (!ur_busy_q)
    begin
      if (!user_txd)                    // start edge
      begin
        ur_busy_q <= 1'b1;
        ur_cnt_q  <= bit_per >> 1;
        ur_idx_q  <= 4'h0;
      end
    end
    else if (ur_cnt_q != '0)
      ur_cnt_q <= ur_cnt_q - 1'b1;
    else
    begin
      ur_cnt_q <= bit_per - 1'b1;
      ur_idx_q <= ur_idx_q + 4'h1;
      if (ur_idx_q == 4'h0 && user_txd)
        ur_busy_q <= 1'b0;              // false start
      else if (ur_idx_q == 4'h9)
      begin
        ur_busy_q <= 1'b0;
        if (user_txd)
          hold_q <= ur_sh_q;
      end
      else if (ur_idx_q != 4'h0)
        ur_sh_q <= {user_txd, ur_sh_q[7:1]};
    end
  //////////////////////////////////////////////////////////////////////////
  // transmit serializer: idle marks between characters
  assign tx_bit = (tx_n_q != 4'h0) ? tx_sh_q[0] : 1'b1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_sh_q  <= 10'h3ff;
      tx_n_q   <= 4'h0;
      hold_v_q <= 1'b0;
    end
    else
    begin
      if (tick && tx_n_q != 4'h0)
      begin
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_n_q  <= tx_n_q - 4'h1;
      end
      else if (tick && hold_v_q)
      begin
        tx_sh_q  <= {1'b1, hold_q, 1'b0};
        tx_n_q   <= 4'ha;
        hold_v_q <= 1'b0;
      end
      if (ur_busy_q && ur_cnt_q == '0 && ur_idx_q == 4'h9 && user_txd)
        hold_v_q <= 1'b1;               // new character wins the clear
    end
  //////////////////////////////////////////////////////////////////////////
  // line coders
  rmd_codec #(.DECODE(1'b0)) u_enc (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .din     (tx_bit),
    .poly    (poly_q),
    .dout    (enc_out)
  );
  assign rx_in = route_q[0] & ~tx_act_q & radio_baseband_in;
  rmd_codec #(.DECODE(1'b1)) u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .din     (rx_in),
    .poly    (poly_q),
    .dout    (dec_out)
  );
  //////////////////////////////////////////////////////////////////////////
  // radio output: data or test tone, only while transmitting
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      radio_baseband_out <= 1'b0;
    else if (!tx_act_q || !route_q[0])
      radio_baseband_out <= 1'b0;
    else if (test_q)
      radio_baseband_out <= tone_q[1];
    else
      radio_baseband_out <= enc_out;
  //////////////////////////////////////////////////////////////////////////
  // receive deframer on the descrambled stream
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rf_n_q  <= 4'h0;
      rf_sh_q <= 8'h00;
      rxc_q   <= 8'h00;
    end
    else if (tick_d_q)
    begin
      if (rf_n_q == 4'h0)
      begin
        if (!dec_out)
          rf_n_q <= 4'h9;               // start bit seen
      end
      else if (rf_n_q == 4'h1)
      begin
        rf_n_q <= 4'h0;
        if (dec_out)
          rxc_q <= rf_sh_q;
      end
      else
      begin
        rf_sh_q <= {dec_out, rf_sh_q[7:1]};
        rf_n_q  <= rf_n_q - 4'h1;
      end
    end
  //////////////////////////////////////////////////////////////////////////
  // user port emitter for received characters
  assign ut_bit = (ut_n_q != 4'h0) ? ut_sh_q[0] : 1'b1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ut_sh_q  <= 10'h3ff;
      ut_n_q   <= 4'h0;
      rxc_v_q  <= 1'b0;
      user_rxd <= 1'b1;
    end
    else
    begin
      user_rxd <= route_q[1] ? ut_bit : 1'b1;
      if (tick && ut_n_q != 4'h0)
      begin
        ut_sh_q <= {1'b1, ut_sh_q[9:1]};
        ut_n_q  <= ut_n_q - 4'h1;
      end
      else if (tick && rxc_v_q)
      begin
        ut_sh_q <= {1'b1, rxc_q, 1'b0};
        ut_n_q  <= 4'ha;
        rxc_v_q <= 1'b0;
      end
      if (tick_d_q && rf_n_q == 4'h1 && dec_out)
        rxc_v_q <= 1'b1;                // new character wins the clear
    end
endmodule
`default_nettype wire

/* File: rmd_modem_top_monitor.sv */
// pin checker for the modem top
// assumes bind onto rmd_modem_top, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module rmd_modem_top_monitor
  import rmd_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       filter_to_tx,
  input wire logic [1:0] filter_cutoff,
  input wire logic       dev_reduced,
  input wire logic [2:0] radio_channel,
  input wire logic [2:0] chan_sel,
  input wire logic       half_channel,
  input wire logic       radio_baseband_out,
  input wire logic       syn_clk,
  input wire logic       syn_data,
  input wire logic       syn_le
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_chan_follow: assert property (
    1'b1 |=> radio_channel == $past(chan_sel)) else $error("chan lag");
  a_half_no_top: assert property (
    half_channel [*4] |-> filter_cutoff != RC_19200) else $error("half top");
  a_dev_half: assert property (
    (half_channel && filter_cutoff == RC_4800) [*3] |-> dev_reduced)
    else $error("dev not reduced");
  a_dev_full: assert property (
    !half_channel [*3] |-> !dev_reduced) else $error("dev reduced");
  a_rx_quiet: assert property (
    !filter_to_tx [*4] |-> !radio_baseband_out) else $error("line in rx");
  a_syn_reload: assert property (
    $changed(filter_to_tx) |-> ##[1:600] syn_le) else $error("no reload");
  a_syn_clk_half: assert property (
    $rose(syn_clk) |-> syn_clk [*4] ##1 !syn_clk) else $error("clk high");
  a_syn_le_width: assert property (
    $rose(syn_le) |-> syn_le [*4] ##1 !syn_le) else $error("le width");
  a_syn_data_hold: assert property (
    syn_clk && $past(syn_clk) |-> $stable(syn_data)) else $error("data");
endmodule
bind rmd_modem_top rmd_modem_top_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .filter_to_tx(filter_to_tx),
  .filter_cutoff(filter_cutoff), .dev_reduced(dev_reduced),
  .radio_channel(radio_channel), .chan_sel(chan_sel),
  .half_channel(half_channel), .radio_baseband_out(radio_baseband_out),
  .syn_clk(syn_clk), .syn_data(syn_data), .syn_le(syn_le));
`default_nettype wire

/* File: rmd_term_model.sv */
// user terminal and radio stand-in: async port plus line recorder
// assumes one pclk domain, bits held one modem bit period
`timescale 1ns/1ps
`default_nettype none
module rmd_term_model (
  input  wire logic pclk,
  output logic      txd,
  input  wire logic rxd,
  input  wire logic line_tx,
  output logic      line_rx
);
  logic rec_q [$];       // recorded line, one entry a cycle
  logic rec_on = 1'b0;   // recorder enable
  initial txd = 1'b1;
  initial line_rx = 1'b0;
  // record transmit line each cycle
  always @(posedge pclk)
  begin
    if (rec_on)
      rec_q.push_back(line_tx);
  end
  // one 8n1 character, lsb first
  task automatic send_byte(input logic [7:0] b, input int bc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      txd <= f[i];
      repeat (bc - 1) @(posedge pclk);
    end
  endtask
  // play the recording back as the received line
  task automatic replay();
    foreach (rec_q[i])
    begin
      @(posedge pclk);
      line_rx <= rec_q[i];
    end
    @(posedge pclk);
    line_rx <= ~line_rx; // released: inverse of last level
  endtask
  // catch one character at mid-bit
  task automatic recv_byte(output logic [7:0] b, input int bc);
    int n = 0;
    b = 8'h00;
    @(negedge pclk);
    while (rxd !== 1'b0 && n < 4000)
    begin
      @(negedge pclk);
      n++;
    end
    repeat (bc + bc / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = rxd;
      repeat (bc) @(negedge pclk);
    end
  endtask
endmodule
`default_nettype wire

/* File: rmd_modem_top_tb.sv */
// self-checking bench for the modem top over apb
// assumes the terminal model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module rmd_modem_top_tb;
  import rmd_pkg::*;
  localparam int BC = 20;  // shortened 9600 bit period
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, test_sw = 1'b0, half = 1'b0;
  logic [7:0]  paddr = 8'h00, rb;
  logic [31:0] pwdata = 32'h0, r, prd;
  logic [2:0]  chan_sel = 3'h0, chan;
  logic [1:0]  cutoff;
  logic [23:0] w;
  logic        pready, pslverr, txd, rxd, lin, lout, to_tx, dev, sc, sd, sl;
  logic        err;
  int          checks = 0, miscompares = 0, cyc = 0, k;
  initial forever #5 pclk = ~pclk;
  rmd_modem_top #(.BIT_CYC_4800(40), .BIT_CYC_9600(BC),
    .BIT_CYC_19200(10)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prd), .pready(pready), .pslverr(pslverr),
    .user_txd(txd), .user_rxd(rxd), .radio_baseband_in(lin),
    .radio_baseband_out(lout), .filter_to_tx(to_tx),
    .filter_cutoff(cutoff), .dev_reduced(dev), .radio_channel(chan),
    .chan_sel(chan_sel), .test_sw(test_sw), .half_channel(half),
    .syn_clk(sc), .syn_data(sd), .syn_le(sl));
  rmd_term_model u_term (.pclk(pclk), .txd(txd), .rxd(rxd),
    .line_tx(lout), .line_rx(lin));
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, answer taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    err = pslverr;
    r = prd;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask
  // shift in one synthesizer load on rising loader clock
  task automatic grab_syn();
    logic p;
    p = 1'b0;
    k = 0;
    w = 24'h0;
    for (int n = 0; sl !== 1'b1 && n < 3000; n++)
    begin
      @(negedge pclk);
      if (sc === 1'b1 && p === 1'b0)
      begin
        w = {w[22:0], sd};
        k++;
      end
      p = sc;
    end
    `CHK("syn bits", 24, k)
  endtask
  // cycles until the line level next changes
  task automatic run_len();
    logic p;
    p = lout;
    for (k = 0; lout === p && k < 500; k++)
      @(negedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    `CHK("cutoff", RC_9600, cutoff)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h19, r)
    apb(1'b0, ADDR_POLY, 32'h0);
    `CHK("poly", 32'h48, r)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("hole", 1'b1, err)
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, ADDR_CTRL, 32'h18 | k);
      settle(1);
      `CHK("rate", (k < 3) ? k[1:0] : RC_19200, cutoff)
    end
    @(posedge pclk);
    half <= 1'b1;
    settle(3);
    `CHK("half pull", RC_9600, cutoff)
    apb(1'b1, ADDR_CTRL, 32'h1a);
    settle(1);
    `CHK("half top", RC_9600, cutoff)
    apb(1'b1, ADDR_CTRL, 32'h18);
    settle(1);
    `CHK("reduced", 1'b1, dev)
    apb(1'b1, ADDR_CTRL, 32'h38);
    settle(1);
    `CHK("adjust", RC_9600, cutoff)
    @(posedge pclk);
    half <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h19);
    $display("rates done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      chan_sel <= i[2:0];
      settle(1);
      `CHK("channel", i[2:0], chan)
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status", 32'h39, r)
    apb(1'b1, ADDR_SYN_RX, 32'h00a5c3);
    apb(1'b1, ADDR_SYN_TX, 32'h5a3c96);
    apb(1'b1, ADDR_CTRL, 32'h1d);
    grab_syn();
    `CHK("tx word", 24'h5a3c96, w)
    `CHK("to tx", 1'b1, to_tx)
    @(posedge pclk);
    test_sw <= 1'b1;
    settle(1);
    for (int i = 0; i < 3; i++)
      run_len();
    `CHK("tone", 2 * BC, k)
    @(posedge pclk);
    test_sw <= 1'b0;
    settle(10 * BC);
    u_term.rec_on = 1'b1;
    settle(25 * BC);
    u_term.send_byte(8'ha5, BC);
    settle(15 * BC);
    u_term.rec_on = 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h19);
    grab_syn();
    `CHK("rx word", 24'h00a5c3, w)
    `CHK("to rx", 1'b0, to_tx)
    fork
      u_term.replay();
      begin
        settle(30 * BC);
        u_term.recv_byte(rb, BC);
      end
    join
    `CHK("rx char", 8'ha5, rb)
    $display("link done");
    wrap_up();
  end
endmodule
`default_nettype wire
